// ---- hw/pwr_state_pkg.sv ----
package pwr_state_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_BUCKS = 3;
  localparam int NUM_SLOTS = 3;
  localparam int NUM_EVENTS = 12;
  localparam int TIMER_W = 8;
  localparam int SLOT_IDX_W = 2;
  localparam int ADDR_W = 8;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_VR_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RAIL_EN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SEQ0 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SEQ1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SEQ2 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SOFT_STOP = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h28;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MODE_PROG_BIT = 0;
  localparam int MODE_QUIESCENT_BIT = 4;
  localparam int VR_ENABLE_BIT = 7;
  localparam int PG_OVERRIDE_BIT = 5;
  localparam int RAIL_A_BIT = 6;
  localparam int RAIL_B_BIT = 4;
  localparam int RAIL_C_BIT = 3;
  localparam int SEQ_MASK_LSB = 0;
  localparam int SEQ_DELAY_LSB = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic MODE_PROG_RESET = 1'b0;
  localparam logic MODE_QUIESCENT_RESET = 1'b1;
  localparam logic [NUM_BUCKS-1:0] RAIL_EN_RESET = 3'h7;
  localparam logic [NUM_SLOTS-1:0][NUM_BUCKS-1:0] SEQ_MASK_RESET = {3'h4, 3'h2, 3'h1};
  localparam logic [TIMER_W-1:0] SEQ_DELAY_RESET = 8'h04;
  localparam logic [TIMER_W-1:0] SOFT_STOP_RESET = 8'h08;
  localparam logic [NUM_EVENTS-1:0] MASK_RESET = 12'h000;

  // Event sources that also force a regulator shutdown
  localparam logic [NUM_EVENTS-1:0] FAULT_EVENT_MASK = 12'h23a;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int POWER_OK_RELEASE_DELAY_NS = 1000;
  localparam int POWER_OK_RELEASE_CYCLES =
    (POWER_OK_RELEASE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [TIMER_W-1:0] POWER_OK_RELEASE_COUNT = TIMER_W'(POWER_OK_RELEASE_CYCLES);

  // ---------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    state_supply_invalid,
    state_pre_enable,
    state_power_on,
    state_regulating,
    state_power_off,
    state_quiescent,
    state_post_enable_nofault,
    state_post_enable_fault
  } power_state_t;

endpackage : pwr_state_pkg

// ---- hw/seq_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface seq_if;
  import pwr_state_pkg::*;
  logic start;
  logic up;
  logic [NUM_SLOTS-1:0][NUM_BUCKS-1:0] slot_mask;
  logic [NUM_SLOTS-1:0][TIMER_W-1:0] slot_delay;
  logic [NUM_BUCKS-1:0][TIMER_W-1:0] soft_stop;
  logic done;
  logic busy;
  logic [NUM_BUCKS-1:0] buck_on;
  logic [NUM_BUCKS-1:0] ramping;

  modport ctrl (
    output start, up, slot_mask, slot_delay, soft_stop,
    input done, busy, buck_on, ramping
  );
  modport seq (
    input start, up, slot_mask, slot_delay, soft_stop,
    output done, busy, buck_on, ramping
  );
endinterface : seq_if
`default_nettype wire

// ---- hw/rail_slot_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
module rail_slot_sequencer
  import pwr_state_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Control side
  seq_if.seq ctl
);

  typedef enum logic [1:0] {ph_idle, ph_load, ph_ramp, ph_delay} seq_phase_t;

  typedef struct packed {
    seq_phase_t phase;
    logic [SLOT_IDX_W-1:0] slot;
    logic up;
    logic [TIMER_W-1:0] delay;
    logic [NUM_BUCKS-1:0] on;
    logic [NUM_BUCKS-1:0][TIMER_W-1:0] ramp;
    logic done;
  } seq_state_t;

  seq_state_t s_q;
  seq_state_t s_d;

  always_comb begin
    logic [NUM_BUCKS-1:0] mask;
    s_d = s_q;
    s_d.done = 1'b0;
    mask = ctl.slot_mask[s_q.slot];
    // Every ramp runs down on its own time
    for (int i = 0; i < NUM_BUCKS; i++) begin
      if (s_q.ramp[i] != '0) begin
        s_d.ramp[i] = s_q.ramp[i] - 1'b1;
      end
    end
    unique case (s_q.phase)
      ph_idle: ;
      ph_load: begin
        s_d.on = s_q.up ? (s_q.on | mask) : (s_q.on & ~mask);
        for (int i = 0; i < NUM_BUCKS; i++) begin
          if (mask[i]) begin
            s_d.ramp[i] = ctl.soft_stop[i];
          end
        end
        s_d.phase = ph_ramp;
      end
      ph_ramp: begin
        // Waiting on all ramps equals waiting on the longest one
        if (s_q.ramp == '0) begin
          s_d.delay = ctl.slot_delay[s_q.slot];
          s_d.phase = ph_delay;
        end
      end
      ph_delay: begin
        if (s_q.delay != '0) begin
          s_d.delay = s_q.delay - 1'b1;
        end else if (s_q.slot == SLOT_IDX_W'(NUM_SLOTS - 1)) begin
          s_d.phase = ph_idle;
          s_d.done = 1'b1;
        end else begin
          s_d.slot = s_q.slot + 1'b1;
          s_d.phase = ph_load;
        end
      end
    endcase
    // A new request restarts from the first slot
    if (ctl.start) begin
      s_d.up = ctl.up;
      s_d.slot = '0;
      s_d.phase = ph_load;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '{phase: ph_idle, slot: '0, up: 1'b0, delay: '0, on: '0, ramp: '0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ctl.done = s_q.done;
  assign ctl.busy = (s_q.phase != ph_idle);
  assign ctl.buck_on = s_q.on;

  for (genvar g = 0; g < NUM_BUCKS; g++) begin : g_ramp
    assign ctl.ramping[g] = (s_q.ramp[g] != '0);
  end

endmodule : rail_slot_sequencer
`default_nettype wire

// ---- hw/power_state_ctrl.sv ----
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module power_state_ctrl
  import pwr_state_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Enable pin and event conditions
  input wire logic regulator_enable_pin_in,
  input wire logic [NUM_EVENTS-1:0] event_cond_in,
  // Open-drain indicators, enable low while pulling low
  output logic power_ok_line_out,
  output logic power_ok_line_oe_n_out,
  output logic general_status_irq_n_out,
  output logic general_status_irq_oe_n_out,
  // Regulator enables
  output logic [NUM_BUCKS-1:0] buck_en_out,
  output logic [NUM_BUCKS-1:0] buck_ramping_out,
  output logic linear_reg_high_en_out,
  output logic linear_reg_low_en_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    power_state_t state;
    power_state_t target;
    logic pin_q;
    logic pg_low;
    logic pg_wait;
    logic [TIMER_W-1:0] pg_cnt;
    logic fault_lock;
    logic override;
    logic prog_mode;
    logic quiescent_en;
    logic [NUM_BUCKS-1:0] rail_en;
    logic [NUM_SLOTS-1:0][NUM_BUCKS-1:0] seq_mask;
    logic [NUM_SLOTS-1:0][TIMER_W-1:0] seq_delay;
    logic [NUM_BUCKS-1:0][TIMER_W-1:0] soft_stop;
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] mask;
    logic dph_write;
    logic [ADDR_W-1:0] dph_addr;
    logic [31:0] rdata;
    logic seq_start;
    logic seq_up;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  seq_if sq ();

  rail_slot_sequencer u_seq (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .ctl(sq.seq)
  );

  assign sq.start = s_q.seq_start;
  assign sq.up = s_q.seq_up;
  assign sq.slot_mask = s_q.seq_mask;
  assign sq.slot_delay = s_q.seq_delay;
  assign sq.soft_stop = s_q.soft_stop;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [NUM_BUCKS-1:0] rail_from_word(input logic [31:0] w);
    return {w[RAIL_C_BIT], w[RAIL_B_BIT], w[RAIL_A_BIT]};
  endfunction : rail_from_word

  function automatic logic [31:0] rail_to_word(input logic [NUM_BUCKS-1:0] r);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[RAIL_A_BIT] = r[0];
    w[RAIL_B_BIT] = r[1];
    w[RAIL_C_BIT] = r[2];
    return w;
  endfunction : rail_to_word

  // Slot index of a sequence register, or NUM_SLOTS when none
  function automatic int slot_of(input logic [ADDR_W-1:0] a);
    if (a == OFS_SEQ0) return 0;
    if (a == OFS_SEQ1) return 1;
    if (a == OFS_SEQ2) return 2;
    return NUM_SLOTS;
  endfunction : slot_of

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic addr_ok;
    logic take;
    logic wr;
    logic locked;
    logic protect;
    logic pin_rise;
    logic pin_fall;
    logic vr_one;
    logic vr_zero;
    logic fault_any;
    logic [31:0] wd;
    logic [NUM_EVENTS-1:0] clr;
    logic [31:0] rd;
    int sl;
    s_d = s_q;
    s_d.seq_start = 1'b0;
    s_d.pin_q = regulator_enable_pin_in;
    pin_rise = regulator_enable_pin_in & ~s_q.pin_q;
    pin_fall = ~regulator_enable_pin_in & s_q.pin_q;
    fault_any = |(event_cond_in & FAULT_EVENT_MASK);
    wd = hwdata_in;
    addr_ok = (haddr_in[31:ADDR_W] == '0);
    take = hsel_in & htrans_in[1] & hready_in;
    // No bus writes while quiescent
    locked = (s_q.state == state_quiescent);
    // Override keeps protected registers frozen
    protect = s_q.override;
    wr = s_q.dph_write & ~locked;
    sl = slot_of(s_q.dph_addr);
    vr_one = wr && (s_q.dph_addr == OFS_VR_CMD) && wd[VR_ENABLE_BIT];
    vr_zero = wr && (s_q.dph_addr == OFS_VR_CMD) && !wd[VR_ENABLE_BIT];

    // -------------------------------------------------------------
    // Address phase
    // -------------------------------------------------------------
    s_d.dph_write = take & hwrite_in & addr_ok;
    s_d.dph_addr = haddr_in[ADDR_W-1:0];
    rd = 32'h0000_0000;
    unique case (haddr_in[ADDR_W-1:0])
      OFS_MODE: begin
        rd[MODE_PROG_BIT] = s_q.prog_mode;
        rd[MODE_QUIESCENT_BIT] = s_q.quiescent_en;
      end
      OFS_VR_CMD: begin
        rd[VR_ENABLE_BIT] = (s_q.state == state_regulating);
        rd[PG_OVERRIDE_BIT] = s_q.override;
      end
      OFS_RAIL_EN: rd = rail_to_word(s_q.rail_en);
      OFS_SEQ0, OFS_SEQ1, OFS_SEQ2: begin
        rd[SEQ_MASK_LSB +: NUM_BUCKS] = s_q.seq_mask[slot_of(haddr_in[ADDR_W-1:0])];
        rd[SEQ_DELAY_LSB +: TIMER_W] = s_q.seq_delay[slot_of(haddr_in[ADDR_W-1:0])];
      end
      OFS_SOFT_STOP: rd[NUM_BUCKS*TIMER_W-1:0] = s_q.soft_stop;
      OFS_STATUS: rd[NUM_EVENTS-1:0] = s_q.status;
      OFS_MASK: rd[NUM_EVENTS-1:0] = s_q.mask;
      OFS_STATE: begin
        rd[2:0] = s_q.state;
        rd[5:3] = sq.buck_on;
        rd[6] = s_q.pg_low;
        rd[7] = s_q.fault_lock;
        rd[8] = sq.busy;
      end
      default: rd = 32'h0000_0000;
    endcase
    if (take && !hwrite_in) begin
      s_d.rdata = addr_ok ? rd : 32'h0000_0000;
    end

    // -------------------------------------------------------------
    // Data phase writes
    // -------------------------------------------------------------
    clr = (wr && s_q.dph_addr == OFS_CLEAR) ? wd[NUM_EVENTS-1:0] : '0;
    if (wr && !protect) begin
      if (s_q.dph_addr == OFS_MODE) begin
        s_d.prog_mode = wd[MODE_PROG_BIT];
        s_d.quiescent_en = wd[MODE_QUIESCENT_BIT];
      end
      if (s_q.dph_addr == OFS_VR_CMD && wd[PG_OVERRIDE_BIT]) begin
        s_d.override = 1'b1;
      end
      // Secure mode leaves the per-rail enables alone
      if (s_q.dph_addr == OFS_RAIL_EN && s_q.prog_mode) begin
        s_d.rail_en = rail_from_word(wd);
      end
      if (sl < NUM_SLOTS) begin
        s_d.seq_mask[sl] = wd[SEQ_MASK_LSB +: NUM_BUCKS];
        s_d.seq_delay[sl] = wd[SEQ_DELAY_LSB +: TIMER_W];
      end
      if (s_q.dph_addr == OFS_SOFT_STOP) begin
        s_d.soft_stop = wd[NUM_BUCKS*TIMER_W-1:0];
      end
      if (s_q.dph_addr == OFS_MASK) begin
        s_d.mask = wd[NUM_EVENTS-1:0];
      end
    end

    // -------------------------------------------------------------
    // Event status: a condition present in the clear cycle wins
    // -------------------------------------------------------------
    s_d.status = (s_q.status & ~clr) | event_cond_in;

    // -------------------------------------------------------------
    // Power ok release after power-on
    // -------------------------------------------------------------
    if (s_q.pg_wait) begin
      if (s_q.pg_cnt <= 8'h01) begin
        s_d.pg_low = 1'b0;
        s_d.pg_wait = 1'b0;
      end else begin
        s_d.pg_cnt = s_q.pg_cnt - 1'b1;
      end
    end

    // -------------------------------------------------------------
    // Power state machine
    // -------------------------------------------------------------
    unique case (s_q.state)
      state_supply_invalid: begin
        s_d.state = state_pre_enable;
      end
      state_pre_enable: begin
        // Bus enable counts only in programmable mode
        if (pin_rise || (s_q.prog_mode && vr_one)) begin
          s_d.seq_start = 1'b1;
          s_d.seq_up = 1'b1;
          s_d.state = state_power_on;
        end
      end
      state_power_on: begin
        if (fault_any) begin
          s_d.pg_low = 1'b1;
          s_d.pg_wait = 1'b0;
          s_d.fault_lock = ~s_q.prog_mode;
          s_d.target = state_post_enable_fault;
          s_d.seq_start = 1'b1;
          s_d.seq_up = 1'b0;
          s_d.state = state_power_off;
        end else if (sq.done) begin
          s_d.state = state_regulating;
          s_d.pg_wait = s_q.pg_low;
          s_d.pg_cnt = POWER_OK_RELEASE_COUNT;
        end
      end
      state_regulating: begin
        // Priority: fault, override, pin, bus command
        if (fault_any) begin
          s_d.pg_low = 1'b1;
          s_d.pg_wait = 1'b0;
          s_d.fault_lock = ~s_q.prog_mode;
          s_d.target = state_post_enable_fault;
          s_d.seq_start = 1'b1;
          s_d.seq_up = 1'b0;
          s_d.state = state_power_off;
        end else if (s_q.override) begin
          s_d.pg_low = 1'b1;
          s_d.pg_wait = 1'b0;
          s_d.target = state_post_enable_nofault;
          s_d.seq_start = 1'b1;
          s_d.seq_up = 1'b0;
          s_d.state = state_power_off;
        end else if (pin_fall && s_q.quiescent_en) begin
          s_d.pg_low = 1'b1;
          s_d.pg_wait = 1'b0;
          s_d.target = state_quiescent;
          s_d.seq_start = 1'b1;
          s_d.seq_up = 1'b0;
          s_d.state = state_power_off;
        end else if (vr_zero && s_q.prog_mode && s_q.quiescent_en) begin
          // Intentional bus shutdown keeps power ok released
          s_d.target = state_quiescent;
          s_d.seq_start = 1'b1;
          s_d.seq_up = 1'b0;
          s_d.state = state_power_off;
        end
        // Quiescent disabled: pin fall leaves rails on and the state in regulating
      end
      state_power_off: begin
        if (sq.done) begin
          s_d.state = s_q.target;
        end
      end
      state_quiescent: begin
        if (pin_rise) begin
          s_d.seq_start = 1'b1;
          s_d.seq_up = 1'b1;
          s_d.state = state_power_on;
        end
      end
      state_post_enable_nofault: begin
        if (vr_one) begin
          s_d.override = 1'b0;
          s_d.seq_start = 1'b1;
          s_d.seq_up = 1'b1;
          s_d.state = state_power_on;
        end
      end
      state_post_enable_fault: begin
        // Secure lockout clears only through a supply cycle
        if (!s_q.fault_lock && (vr_one || pin_rise)) begin
          s_d.seq_start = 1'b1;
          s_d.seq_up = 1'b1;
          s_d.state = state_power_on;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '{
        state: state_supply_invalid,
        target: state_quiescent,
        pin_q: 1'b0,
        pg_low: 1'b1,
        pg_wait: 1'b0,
        pg_cnt: '0,
        fault_lock: 1'b0,
        override: 1'b0,
        prog_mode: MODE_PROG_RESET,
        quiescent_en: MODE_QUIESCENT_RESET,
        rail_en: RAIL_EN_RESET,
        seq_mask: SEQ_MASK_RESET,
        seq_delay: {NUM_SLOTS{SEQ_DELAY_RESET}},
        soft_stop: {NUM_BUCKS{SOFT_STOP_RESET}},
        status: '0,
        mask: MASK_RESET,
        dph_write: 1'b0,
        dph_addr: '0,
        rdata: 32'h0000_0000,
        seq_start: 1'b0,
        seq_up: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = s_q.rdata;

  // Only the pull low is ever driven
  assign power_ok_line_out = 1'b0;
  assign power_ok_line_oe_n_out = ~s_q.pg_low;
  assign general_status_irq_n_out = 1'b0;
  // Interrupt has no path into the regulator logic
  assign general_status_irq_oe_n_out = ~|(s_q.status & ~s_q.mask);

  assign buck_en_out = sq.buck_on & s_q.rail_en;
  assign buck_ramping_out = sq.ramping;
  assign linear_reg_high_en_out = (s_q.state != state_quiescent);
  assign linear_reg_low_en_out = (s_q.state != state_quiescent);

endmodule : power_state_ctrl
`default_nettype wire

// ---- testbench/power_state_ctrl_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module pwr_ctrl_checker
  import pwr_state_pkg::*;
(
  // Watched ports
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic regulator_enable_pin_in,
  input wire logic [NUM_EVENTS-1:0] event_cond_in,
  input wire logic power_ok_line_out,
  input wire logic power_ok_line_oe_n_out,
  input wire logic general_status_irq_n_out,
  input wire logic general_status_irq_oe_n_out,
  input wire logic [NUM_BUCKS-1:0] buck_en_out,
  input wire logic linear_reg_high_en_out
);
  // Cycles with every buck on, saturating so it never wraps
  logic [5:0] on_q;
  logic [5:0] on_d;
  always_comb on_d = !(&buck_en_out) ? 6'h0 : on_q + {5'h0, ~&on_q};
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) on_q <= 6'h0;
    else on_q <= on_d;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  chk_od_low: assert property (!power_ok_line_out && !general_status_irq_n_out)
    else $error("open drain pin driven high");
  chk_irq_hold: assert property (!general_status_irq_oe_n_out && event_cond_in != '0
    |=> !general_status_irq_oe_n_out) else $error("irq released early");
  chk_quiet_off: assert property (!linear_reg_high_en_out |-> buck_en_out == '0)
    else $error("bucks on in quiescent");
  chk_pin_fall: assert property (power_ok_line_oe_n_out && $fell(regulator_enable_pin_in)
    |-> ##[1:2] !power_ok_line_oe_n_out) else $error("power ok kept on pin fall");
  chk_pg_delay: assert property ($rose(power_ok_line_oe_n_out) |-> on_q >= 6'h28)
    else $error("power ok released early");
  chk_order_b: assert property ($changed(buck_en_out[1]) |-> buck_en_out[0] == buck_en_out[1])
    else $error("slot order broken");
  chk_order_c: assert property ($changed(buck_en_out[2]) |-> buck_en_out[1] == buck_en_out[2])
    else $error("slot order broken");
  chk_slot_gap: assert property ($fell(buck_en_out[0]) |=> buck_en_out[1] [*8])
    else $error("next slot too soon");
  chk_fault_pg: assert property ((event_cond_in & FAULT_EVENT_MASK) != '0
    |-> ##[1:4] !power_ok_line_oe_n_out) else $error("power ok kept on fault");
  chk_irq_calm: assert property ($fell(general_status_irq_oe_n_out) && &buck_en_out
    && ($past(event_cond_in) & FAULT_EVENT_MASK) == '0 |=> &buck_en_out) else $error("irq moved bucks");
endmodule : pwr_ctrl_checker
bind power_state_ctrl pwr_ctrl_checker chk_i (.clock_in, .reset_n_in, .regulator_enable_pin_in,
  .event_cond_in, .power_ok_line_out, .power_ok_line_oe_n_out, .general_status_irq_n_out,
  .general_status_irq_oe_n_out, .buck_en_out, .linear_reg_high_en_out);
`default_nettype wire

// ---- testbench/host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_model
  import pwr_state_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Bus master
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  // Enable pin
  output logic pin_out
);
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h0;
    hwdata_out = 32'h0;
    pin_out = 1'b0;
  end
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock_in);
    hsel_out <= 1'b1;
    htrans_out <= 2'h2;
    haddr_out <= a;
    hwrite_out <= w;
    hsize_out <= 3'h2;
    do @(posedge clock_in); while (hready_in !== 1'b1);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= d;
    do @(posedge clock_in); while (hready_in !== 1'b1);
    r = hrdata_in;
    // Stale data must not look valid
    hwdata_out <= ~d;
  endtask : xfer
  task automatic set_pin(input logic v);
    @(posedge clock_in);
    pin_out <= v;
  endtask : set_pin
endmodule : host_model
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench
  import pwr_state_pkg::*;
;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [NUM_EVENTS-1:0] ev = '0;
  logic hsel, hwrite, hready, hresp, pin, pg, pg_n, irq, irq_n, lin_h, lin_l, hold;
  logic [1:0] htrans;
  logic [2:0] bucks, ramp, hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  integer seed = 32'hce9d;
  int error_cnt = 0;
  int n_checks = 0;
  always #12.5 clock_in = ~clock_in;
  host_model host (.clock_in(clock_in), .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
    .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata), .hready_in(hready), .hrdata_in(hrdata),
    .pin_out(pin));
  power_state_ctrl dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .regulator_enable_pin_in(pin),
    .event_cond_in(ev), .power_ok_line_out(pg), .power_ok_line_oe_n_out(pg_n), .general_status_irq_n_out(irq),
    .general_status_irq_oe_n_out(irq_n), .buck_en_out(bucks), .buck_ramping_out(ramp),
    .linear_reg_high_en_out(lin_h), .linear_reg_low_en_out(lin_l));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic ck(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : ck
  function automatic logic [31:0] exp_bucks(input int i);
    return FAULT_EVENT_MASK[i] ? 32'h0 : 32'h7;
  endfunction : exp_bucks
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rd);
    ck("read", e, rd & m);
  endtask : rdc
  task automatic idle(input int n);
    repeat (n) @(negedge clock_in);
  endtask : idle
  task automatic up();
    for (int n = 0; n < 300 && pg_n !== 1'b1; n++) @(negedge clock_in);
    ck("power ok", 32'h1, 32'(pg_n));
    ck("bucks", 32'h7, 32'(bucks));
  endtask : up
  initial begin
    // Whole run needs a few thousand cycles
    repeat (20000) @(posedge clock_in);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    idle(3);
    reset_n_in <= 1'b1;
    idle(2);
    ck("state", 32'h2, 32'({bucks, lin_h, pg_n}));
    wr(OFS_VR_CMD, 32'h80);
    idle(60);
    ck("bucks", 32'h0, 32'(bucks));
    host.set_pin(1'b1);
    up();
    rdc(OFS_VR_CMD, 32'h80, 32'h80);
    wr(OFS_RAIL_EN, $random(seed) & ~32'h58);
    wr(OFS_VR_CMD, 32'h0);
    idle(60);
    ck("bucks", 32'h7, 32'({hresp, bucks}));
    wr(OFS_VR_CMD, 32'h20);
    idle(80);
    ck("bucks pg", 32'h0, 32'({bucks, pg_n}));
    wr(OFS_SEQ0, 32'h0);
    rdc(OFS_SEQ0, 32'hff07, 32'h0401);
    wr(OFS_VR_CMD, 32'h80);
    up();
    wr(OFS_VR_CMD, 32'h0);
    idle(60);
    ck("bucks", 32'h7, 32'(bucks));
    host.set_pin(1'b0);
    idle(100);
    ck("quiet", 32'h0, 32'({bucks, lin_h, lin_l, pg_n}));
    wr(OFS_SEQ0, 32'h0);
    host.set_pin(1'b1);
    up();
    rdc(OFS_SEQ0, 32'hff07, 32'h0401);
    for (int i = 0; i < NUM_EVENTS; i++) begin
      // Fault in secure mode locks until reset, so each source gets a fresh power cycle
      reset_n_in <= 1'b0;
      host.set_pin(1'b0);
      idle(3);
      reset_n_in <= 1'b1;
      host.set_pin(1'b1);
      up();
      hold = 1'($random(seed));
      @(posedge clock_in);
      ev <= 12'h1 << i;
      @(posedge clock_in);
      ev <= hold ? ev : '0;
      idle(2);
      ck("irq", 32'h0, 32'(irq_n));
      rdc(OFS_STATUS, 32'hfff, 32'h1 << i);
      idle(100);
      ck("bucks", exp_bucks(i), 32'(bucks));
      wr(OFS_CLEAR, 32'h1 << i);
      idle(2);
      ck("irq", 32'(!hold), 32'(irq_n));
      ev <= '0;
      wr(OFS_CLEAR, 32'h1 << i);
      idle(2);
      ck("irq", 32'h1, 32'(irq_n));
      if (FAULT_EVENT_MASK[i]) begin
        host.set_pin(1'b0);
        host.set_pin(1'b1);
        wr(OFS_VR_CMD, 32'h80);
        idle(100);
        ck("locked", 32'h0, 32'({bucks, pg_n}));
      end
    end
    // Programmable mode: rail bits and bus disable act
    wr(OFS_MODE, 32'h11);
    wr(OFS_RAIL_EN, 32'h18);
    idle(2);
    ck("prog rails", 32'h6, 32'(bucks));
    wr(OFS_RAIL_EN, 32'h58);
    wr(OFS_VR_CMD, 32'h0);
    idle(4);
    ck("ramping", 32'h1, 32'(ramp));
    idle(96);
    ck("prog off", 32'h1, 32'({bucks, pg_n}));
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
